// ===== core/pioc_params.svh
// Register offsets, field positions and reset values of the parallel port block
`ifndef PIOC_PARAMS_SVH
`define PIOC_PARAMS_SVH
`define PIOC_ADDR_C_DATA   8'h62
`define PIOC_ADDR_D_DATA   8'h63
`define PIOC_ADDR_E_DATA   8'h64
`define PIOC_ADDR_F_DATA   8'h65
`define PIOC_ADDR_G_DATA   8'h66
`define PIOC_ADDR_C_DIR    8'h72
`define PIOC_ADDR_D_DIR    8'h73
`define PIOC_ADDR_E_DIR    8'h74
`define PIOC_ADDR_F_DIR    8'h75
`define PIOC_DIR_RESET     8'h00
`define PIOC_ALL_ONES      8'hFF
`define PIOC_UNMAPPED      8'hFF
`define PIOC_E_LOW_MASK    8'h0F
`define PIOC_G_MASK        8'h3F
`define PIOC_NUM_PORTS     4
`define PIOC_PORT_C        2'h0
`define PIOC_PORT_D        2'h1
`define PIOC_PORT_E        2'h2
`define PIOC_PORT_F        2'h3
`endif

// ===== core/pioc_pkg.sv
// Types shared by the parallel port block
package pioc_pkg;
	typedef enum logic [1:0] {
		PIOC_MODE_SINGLE = 2'b00,
		PIOC_MODE_EXP1   = 2'b01,
		PIOC_MODE_EXP2   = 2'b10,
		PIOC_MODE_PROM   = 2'b11
	} pioc_mode_t;

	typedef struct packed {
		logic [7:0] c;
		logic [7:0] d;
		logic [7:0] e;
		logic [7:0] f;
	} pioc_bytes_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       rd;
		logic       wr;
		logic [7:0] wdata;
	} pioc_bus_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [3:0]  ctrl_out;
		logic [3:0]  ctrl_oe;
		logic [7:0]  data_out;
		logic        data_oe;
	} pioc_membus_t;
endpackage

// ===== core/pioc_latch_mem.sv
// Output latch storage for four ports, no reset, read straight from the storage register
`timescale 1ns/1ps
`default_nettype none
`include "pioc_params.svh"
module pioc_latch_mem
	import pioc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        wr_en,
	input  wire logic [1:0]  wr_port,
	input  wire logic [7:0]  wr_data,
	output var  pioc_bytes_t latch_q
);
	pioc_bytes_t mem_reg;
	pioc_bytes_t mem_next;

	// Latches have no reset, contents survive a system reset
	always_comb begin
		mem_next = mem_reg;
		if (wr_en) begin
			case (wr_port)
				`PIOC_PORT_C: mem_next.c = wr_data;
				`PIOC_PORT_D: mem_next.d = wr_data;
				`PIOC_PORT_E: mem_next.e = wr_data;
				default:      mem_next.f = wr_data;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		mem_reg <= mem_next;
	end

	assign latch_q = mem_reg;
endmodule
`default_nettype wire

// ===== core/pioc_ports.sv
// Parallel ports C to G: direction, latches, expanded mode pin takeover
// Functional notes
// - Direction bit 1 drives pin, 0 inputs
// - Port D output bits read as one
// - Mode 1 port D is address, direction ignored
// - Mode 2 port D address where direction set
// - Expanded modes read D, E, F as ones
// - Mode 1 port E low latch, high bus control
// - Mode 2 E high control, low latch if set
// - Expanded modes port F is data bus
// - Port G six input bits, read latch
// - Reset clears all direction bits
// - Output latches keep contents over reset
// - Expanded modes port C is address bus
`timescale 1ns/1ps
`default_nettype none
`include "pioc_params.svh"
module pioc_ports
	import pioc_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire pioc_mode_t   mode,
	input  wire pioc_bus_t    bus,
	output var  logic [7:0]   rdata,
	input  wire pioc_membus_t membus,
	output var  logic [7:0]   membus_data_in,
	input  wire pioc_bytes_t  pin_in,
	output var  pioc_bytes_t  pin_out,
	output var  pioc_bytes_t  pin_oe,
	input  wire logic [5:0]   port_g_in
);
	typedef struct packed {
		pioc_bytes_t dir;
		pioc_bytes_t in_lat;
		logic [5:0]  g_lat;
		logic [7:0]  rdata;
	} pioc_state_t;

	pioc_state_t st_reg;
	pioc_state_t st_next;
	pioc_bytes_t out_lat;
	logic        lat_wr;
	logic [1:0]  lat_port;
	logic [2:0]  bus_port;
	logic        expanded;

	// Maps a data address onto a port index; used for latch writes only
	function automatic logic [2:0] data_port(input logic [7:0] a);
		case (a)
			`PIOC_ADDR_C_DATA: data_port = {1'b1, `PIOC_PORT_C};
			`PIOC_ADDR_D_DATA: data_port = {1'b1, `PIOC_PORT_D};
			`PIOC_ADDR_E_DATA: data_port = {1'b1, `PIOC_PORT_E};
			`PIOC_ADDR_F_DATA: data_port = {1'b1, `PIOC_PORT_F};
			default:           data_port = 3'h0;
		endcase
	endfunction

	assign expanded = (mode == PIOC_MODE_EXP1) || (mode == PIOC_MODE_EXP2);
	// Select on a function result is not legal, so decode once into a net
	assign bus_port = data_port(bus.addr);
	assign lat_wr   = bus.wr && bus_port[2];
	assign lat_port = bus_port[1:0];

	pioc_latch_mem u_latch (
		.sys_clk (sys_clk),
		.wr_en   (lat_wr),
		.wr_port (lat_port),
		.wr_data (bus.wdata),
		.latch_q (out_lat)
	);

	// Pin drive; data reads use sampled pins, but D and low E output bits read one, high E and F ones the latch; membus_data_in takes pin_in.f combinationally
	always_comb begin
		pin_out = out_lat;
		pin_oe  = st_reg.dir;
		membus_data_in = pin_in.f;
		if (expanded) begin
			pin_out.c = membus.addr[7:0];
			pin_oe.c  = `PIOC_ALL_ONES;
			pin_out.d = membus.addr[15:8];
			pin_out.e = {membus.ctrl_out, out_lat.e[3:0]};
			pin_oe.e[7:4] = membus.ctrl_oe;
			pin_out.f = membus.data_out;
			pin_oe.f  = {8{membus.data_oe}};
			if (mode == PIOC_MODE_EXP1) begin
				pin_oe.d = `PIOC_ALL_ONES;
				pin_out.e[3:0] = out_lat.e[3:0];
				pin_oe.e[3:0]  = 4'hF;
			end else begin
				pin_oe.d = st_reg.dir.d;
				pin_oe.e[3:0] = st_reg.dir.e[3:0];
			end
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.in_lat = pin_in;
		st_next.g_lat  = port_g_in;
		if (bus.wr) begin
			case (bus.addr)
				`PIOC_ADDR_C_DIR: st_next.dir.c = bus.wdata;
				`PIOC_ADDR_D_DIR: st_next.dir.d = bus.wdata;
				`PIOC_ADDR_E_DIR: st_next.dir.e = bus.wdata;
				`PIOC_ADDR_F_DIR: st_next.dir.f = bus.wdata;
				default: ;
			endcase
		end
		if (bus.rd) begin
			case (bus.addr)
				`PIOC_ADDR_C_DATA: st_next.rdata = expanded ? `PIOC_ALL_ONES : st_reg.in_lat.c;
				`PIOC_ADDR_D_DATA: st_next.rdata = expanded ? `PIOC_ALL_ONES : (st_reg.in_lat.d | st_reg.dir.d);
				`PIOC_ADDR_E_DATA: st_next.rdata = expanded ? `PIOC_ALL_ONES :
					(((st_reg.in_lat.e & ~st_reg.dir.e) | (out_lat.e & st_reg.dir.e)) |
					(st_reg.dir.e & `PIOC_E_LOW_MASK));
				`PIOC_ADDR_F_DATA: st_next.rdata = expanded ? `PIOC_ALL_ONES :
					((st_reg.in_lat.f & ~st_reg.dir.f) | (out_lat.f & st_reg.dir.f));
				`PIOC_ADDR_G_DATA: st_next.rdata = {2'b00, st_reg.g_lat};
				`PIOC_ADDR_C_DIR:  st_next.rdata = st_reg.dir.c;
				`PIOC_ADDR_D_DIR:  st_next.rdata = st_reg.dir.d;
				`PIOC_ADDR_E_DIR:  st_next.rdata = st_reg.dir.e;
				`PIOC_ADDR_F_DIR:  st_next.rdata = st_reg.dir.f;
				default:           st_next.rdata = `PIOC_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg.dir    <= {`PIOC_NUM_PORTS{`PIOC_DIR_RESET}};
			st_reg.in_lat <= '0;
			st_reg.g_lat  <= 6'h00;
			st_reg.rdata  <= 8'h00;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata = st_reg.rdata;
endmodule
`default_nettype wire

// ===== sim/pioc_ports_asserts.sv
// Port checker for the parallel port block
`timescale 1ns/1ps
`default_nettype none
module pioc_ports_asserts
	import pioc_pkg::*;
(
	input wire logic         sys_clk,
	input wire logic         rst_n,
	input wire pioc_mode_t   mode,
	input wire pioc_bus_t    bus,
	input wire logic [7:0]   rdata,
	input wire pioc_membus_t membus,
	input wire logic [7:0]   membus_data_in,
	input wire pioc_bytes_t  pin_in,
	input wire pioc_bytes_t  pin_out,
	input wire pioc_bytes_t  pin_oe,
	input wire logic [5:0]   port_g_in
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire exp_m = mode inside {PIOC_MODE_EXP1, PIOC_MODE_EXP2};
	sequence s_rd_xp;
		exp_m && bus.rd && bus.addr inside {8'h63, 8'h64, 8'h65};
	endsequence
	chk_exp_ones: assert property (s_rd_xp ##1 exp_m |-> rdata == 8'hFF) else $error("exp read");
	chk_g_top: assert property (bus.rd && bus.addr == 8'h66 |=> rdata[7:6] == 2'h0) else $error("g read");
	chk_c_addr: assert property (exp_m |-> pin_oe.c == 8'hFF && pin_out.c == membus.addr[7:0]) else $error("c");
	chk_d_addr: assert property (mode == PIOC_MODE_EXP1 |-> pin_oe.d == 8'hFF && pin_out.d == membus.addr[15:8])
		else $error("d");
	chk_e_ctrl: assert property (exp_m |-> pin_oe.e[7:4] == membus.ctrl_oe) else $error("e");
	chk_f_bus: assert property (exp_m |-> pin_oe.f == {8{membus.data_oe}} && membus_data_in == pin_in.f)
		else $error("f");
	chk_d_mode2: assert property (mode == PIOC_MODE_EXP2 && bus.wr && bus.addr == 8'h73 ##1 mode == PIOC_MODE_EXP2
		|-> pin_oe.d == $past(bus.wdata)) else $error("d dir");
	chk_dir_oe: assert property (mode == PIOC_MODE_SINGLE && bus.wr && bus.addr == 8'h72 ##1 mode == PIOC_MODE_SINGLE
		|-> pin_oe.c == $past(bus.wdata)) else $error("c dir");
endmodule
`default_nettype wire

// ===== sim/pioc_pins.sv
// Pin model for the parallel port block
`timescale 1ns/1ps
`default_nettype none
module pioc_pins
	import pioc_pkg::*;
(
	input  wire pioc_bytes_t pin_out,
	input  wire pioc_bytes_t pin_oe,
	input  wire pioc_bytes_t ext,
	output var  pioc_bytes_t pin_in
);
	// Released pins show the outside pattern, never the last driven value
	assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Testbench for the parallel port block
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import pioc_pkg::*;
;
	logic         sys_clk = 0;
	logic         rst_n = 0;
	pioc_mode_t   mode = PIOC_MODE_SINGLE;
	pioc_bus_t    bus = '0;
	pioc_membus_t mb = '0;
	pioc_bytes_t  ext = 32'hA1B2C3D4;
	pioc_bytes_t  pin_in, pin_out, pin_oe;
	logic [7:0]   rdata, mbi;
	logic [5:0]   g = 6'h2A;
	int           errors = 0, checked = 0;
	pioc_ports i_pioc_ports (.sys_clk, .rst_n, .mode, .bus, .rdata, .membus(mb), .membus_data_in(mbi),
		.pin_in, .pin_out, .pin_oe, .port_g_in(g));
	pioc_pins i_pioc_pins (.pin_out, .pin_oe, .ext, .pin_in);
	initial forever #12.5 sys_clk = ~sys_clk;
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		checked++;
		if (s !== e) begin
			errors++;
			$display("Error %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge sys_clk) bus <= '{a, 1'b0, 1'b1, d};
		@(negedge sys_clk) bus.wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(negedge sys_clk) bus <= '{a, 1'b1, 1'b0, 8'h00};
		@(negedge sys_clk) bus.rd <= 1'b0;
		chk($sformatf("rd %h", a), e, rdata);
	endtask
	task automatic t_reset;
		for (int i = 0; i < 4; i++) rd(8'h72 + i[7:0], 8'h00);
	endtask
	task automatic t_single;
		for (int i = 0; i < 4; i++) wr(8'h62 + i[7:0], 8'h96 ^ i[7:0]);
		rd(8'h62, ext.c);
		for (int i = 0; i < 4; i++) wr(8'h72 + i[7:0], 8'hFF);
		rd(8'h75, 8'hFF);
		chk("pin_f", 8'h95, pin_out.f & pin_oe.f);
		rd(8'h62, 8'h96);
		rd(8'h65, 8'h95);
		rd(8'h63, 8'hFF);
		rd(8'h64, 8'h9F);
		wr(8'h73, 8'h0F);
		rd(8'h63, {ext.d[7:4], 4'hF});
		rd(8'h66, 8'h2A);
		rd(8'h70, 8'hFF);
	endtask
	task automatic t_keep;
		@(negedge sys_clk) rst_n <= 1'b0;
		@(negedge sys_clk) chk("oe_d", 8'h00, pin_oe.d);
		chk("rdata_rst", 8'h00, rdata);
		rst_n <= 1'b1;
		wr(8'h73, 8'hFF);
		chk("pin_d", 8'h97, pin_out.d);
	endtask
	task automatic t_exp;
		mb = '{16'hA55A, 4'h5, 4'hC, 8'h3C, 1'b1};
		mode = PIOC_MODE_EXP1;
		for (int i = 0; i < 3; i++) rd(8'h63 + i[7:0], 8'hFF);
		chk("pin_c", 8'h5A, pin_out.c);
		chk("pin_d", 8'hA5, pin_out.d);
		chk("oe_e", 8'hCF, pin_oe.e);
		chk("oe_f", 8'hFF, pin_oe.f);
		chk("mb_in", 8'h3C, mbi);
		mode = PIOC_MODE_EXP2;
		wr(8'h73, 8'h0F);
		wr(8'h74, 8'h03);
		chk("oe_d", 8'h0F, pin_oe.d);
		chk("oe_e", 8'hC3, pin_oe.e);
	endtask
	task automatic results;
		if (errors == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge sys_clk);
		rst_n = 1'b1;
		t_reset;
		t_single;
		t_keep;
		t_exp;
		results;
	end
	// Run needs about 1.5 us
	initial begin
		#20us;
		errors++;
		results;
	end
endmodule
bind pioc_ports pioc_ports_asserts i_pioc_ports_asserts (.sys_clk, .rst_n, .mode, .bus, .rdata, .membus,
	.membus_data_in, .pin_in, .pin_out, .pin_oe, .port_g_in);
`default_nettype wire
